// ### dv/fcd_mem_model.sv
// Behavioural shared memory answering the controller's bus requests
`timescale 1ns/1ps

module fcd_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus from the controller
  input wire fcd_pkg::fcd_mem_req_type mem_out,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_cnt; // Cycles left before the answer
  logic slow; // Alternates prompt and slow answers
  logic [31:0] last_waddr; // Address of the latest write
  logic [31:0] last_wdata; // Data of the latest write
  int wr_count; // Writes seen so far

  ////////////////////////////////////////////////////////////////////
  // Answer each request once; read data is garbage outside the answer
  always_ff @(posedge ref_clk) begin
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5a5a5a;
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      last_waddr <= 32'h00000000;
      last_wdata <= 32'h00000000;
      wr_count <= 0;
    end else if (mem_ack) begin
      // Request still held in the ack cycle: do not answer twice
      mem_ack <= 1'b0;
    end else if (mem_out.req && wait_cnt == 2'h0) begin
      mem_ack <= 1'b1;
      slow <= ~slow;
      wait_cnt <= slow ? 2'h0 : 2'h2;
      if (mem_out.we) begin
        last_waddr <= mem_out.addr;
        last_wdata <= mem_out.wdata;
        wr_count <= wr_count + 1;
      end else begin
        mem_rdata <= {~mem_out.addr[15:0], mem_out.addr[15:0]};
      end
    end else if (mem_out.req) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the four-channel DMA controller
`timescale 1ns/1ps

module tb_top;
  // Clock, reset, register bus
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Request sources, memory bus, completion
  logic [3:0] ext_irq_pin = 4'hf;
  logic [28:0] periph_irq = 29'h0;
  logic cpu_req = 1'b0;
  logic cpu_gnt;
  fcd_pkg::fcd_mem_req_type mem_out;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic [3:0] done_irq;
  // Bench bookkeeping
  int fail_count = 0;
  int num_checks = 0;
  int done_cnt[4] = '{0, 0, 0, 0};
  int n0;
  logic [31:0] rd;

  fcd_dma DUT (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq_pin, .periph_irq, .cpu_req, .cpu_gnt,
    .mem_out, .mem_ack, .mem_rdata, .done_irq);
  fcd_mem_model mem (.ref_clk, .rst, .mem_out, .mem_ack, .mem_rdata);

  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////
  // Count completion pulses and watch bus ownership
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) if (done_irq[i] === 1'b1) done_cnt[i]++;
    if (!rst && mem_out.req === 1'b1 && cpu_gnt !== 1'b0) begin
      fail_count++;
      $display("Error at %0t: grant %h with request %h", $time, cpu_gnt, mem_out.req);
    end
  end

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  // Poll status until nothing pending or busy
  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, fcd_pkg::STATUS_ADDR, 32'h0);
      n++;
    end while ((rd[8] !== 1'b0 || rd[3:0] !== 4'h0) && n < 40);
    if (rd[8] !== 1'b0 || rd[3:0] !== 4'h0) begin
      fail_count++;
      $display("Error at %0t: status %h expected %h", $time, rd, 32'h0);
    end
  endtask

  // Set up one channel, mode last
  task automatic cfg(input int ch, input logic [5:0] md, input logic [31:0] cnt, src, dst, sl);
    logic [7:0] b;
    b = 8'(ch * 32);
    wb(1'b1, b + 8'h04, cnt);
    wb(1'b1, b + 8'h0c, src);
    wb(1'b1, b + 8'h14, dst);
    wb(1'b1, b + 8'h1c, sl);
    wb(1'b1, b, {26'h0, md});
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    cpu_req <= 1'b1;
    // Single mode, long words, both addresses advancing
    cfg(0, 6'h39, 32'h2, 32'h100, 32'h01fffff0, 32'h0);
    wb(1'b1, 8'h1c, 32'h80);
    idle();
    chk(mem.last_waddr, 32'h01fffff0);
    chk(mem.last_wdata, 32'hfeff0100);
    wb(1'b0, 8'h04, 32'h0); chk(rd, 32'h1);
    chk(32'(done_cnt[0]), 32'h0);
    wb(1'b1, 8'h08, 32'h5);
    wb(1'b1, 8'h1c, 32'h80); idle();
    chk(32'(done_cnt[0]), 32'h1);
    wb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
    wb(1'b0, 8'h0c, 32'h0); chk(rd, 32'h108);
    wb(1'b0, 8'h14, 32'h0); chk(rd, 32'h01fffff8);
    wb(1'b1, 8'h1c, 32'h80); idle();
    chk(32'(mem.wr_count), 32'h2);
    // Repeat mode, bytes, reload at terminal count
    cfg(2, 6'h33, 32'h1, 32'h2a5, 32'h300, 32'h0);
    wb(1'b1, 8'h48, 32'h2);
    wb(1'b1, 8'h50, 32'hfe000000);
    wb(1'b1, 8'h58, 32'hfe000100);
    wb(1'b1, 8'h5c, 32'h80); idle();
    chk(mem.last_waddr, 32'h300);
    chk({24'h0, mem.last_wdata[7:0]}, 32'ha5);
    chk(32'(done_cnt[2]), 32'h1);
    wb(1'b0, 8'h44, 32'h0); chk(rd, 32'h2);
    wb(1'b0, 8'h4c, 32'h0); chk(rd, 32'hfe000000);
    wb(1'b0, 8'h54, 32'h0); chk(rd, 32'hfe000100);
    wb(1'b1, 8'h5c, 32'h80); idle();
    chk(mem.last_waddr, 32'hfe000100);
    // Two peripheral requests at once, channel 1 fixed words
    cfg(1, 6'h05, 32'h4, 32'h400, 32'h500, 32'h3);
    cfg(3, 6'h39, 32'h4, 32'h600, 32'h700, 32'h4);
    @(posedge ref_clk) periph_irq <= 29'h3;
    @(posedge ref_clk) periph_irq <= 29'h0;
    idle();
    chk(mem.last_waddr, 32'h700);
    wb(1'b0, 8'h2c, 32'h0); chk(rd, 32'h400);
    wb(1'b0, 8'h24, 32'h0); chk(rd, 32'h3);
    // Falling edge on pin 0, both edges on pin 3
    cfg(0, 6'h39, 32'h4, 32'h100, 32'h800, 32'h1);
    wb(1'b1, 8'h7c, 32'h2);
    n0 = mem.wr_count;
    @(posedge ref_clk) ext_irq_pin <= 4'h6;
    repeat (4) @(posedge ref_clk);
    idle();
    @(posedge ref_clk) ext_irq_pin <= 4'hf;
    repeat (4) @(posedge ref_clk);
    idle();
    chk(32'(mem.wr_count - n0), 32'h3);
    // Disabled channel and out-of-window source do nothing
    n0 = mem.wr_count;
    wb(1'b1, 8'h40, 32'h0);
    wb(1'b1, 8'h5c, 32'h80); idle();
    cfg(3, 6'h39, 32'h4, 32'h02000000, 32'h700, 32'h80); idle();
    chk(32'(mem.wr_count - n0), 32'h0);
    wb(1'b0, 8'h7c, 32'h0); chk({31'h0, rd[9]}, 32'h1);
    // Count clamp, unmapped read, idle grant
    wb(1'b1, 8'h60, 32'h0);
    wb(1'b1, 8'h64, 32'h02000000);
    wb(1'b0, 8'h64, 32'h0); chk(rd, {7'h0, fcd_pkg::MAX_UNITS});
    wb(1'b0, 8'hc0, 32'h0); chk(rd, 32'h0);
    chk({31'h0, cpu_gnt}, 32'h1);
    final_report();
  end
endmodule

// ### hdl/fcd_dma.sv
// Four-channel cycle-steal DMA controller with its data FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO between the read and write halves of a transfer
module fcd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wp; // Write pointer
  logic [AW-1:0] rp; // Read pointer
  logic [AW:0] fill; // Words held
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Controller top
module fcd_dma #(
  parameter int PERIPH_N = 29,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Request sources
  input wire logic [3:0] ext_irq_pin,
  input wire logic [PERIPH_N-1:0] periph_irq,
  // Shared memory bus
  input wire logic cpu_req,
  output logic cpu_gnt,
  output fcd_pkg::fcd_mem_req_type mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Completion requests
  output logic [3:0] done_irq
);
  typedef enum {ST_IDLE, ST_READ, ST_POP, ST_WRITE, ST_UPDATE} fcd_state_type;

  fcd_pkg::fcd_mode_type mode [4]; // Channel mode registers
  logic [24:0] count [4]; // Working transfer counters
  logic [24:0] crld [4]; // Count reload values
  logic [31:0] src [4]; // Working source addresses
  logic [31:0] srld [4]; // Source reload values
  logic [31:0] dst [4]; // Working destination addresses
  logic [31:0] drld [4]; // Destination reload values
  logic [4:0] rsel [4]; // Request source selects
  logic [3:0] pend; // Pending requests
  logic [3:0] err; // Address errors, sticky
  logic [3:0] trig; // Request events this cycle
  logic [3:0] on; // Channel enabled with nonzero count
  logic [3:0] pin_s1; // Pin synchroniser, first stage
  logic [3:0] pin_s2; // Pin synchroniser, second stage
  logic [3:0] pin_d; // Delayed pin level for edges
  fcd_state_type st; // Engine state
  logic [1:0] cur; // Channel being served
  logic [1:0] pk; // Highest-priority pending channel
  logic bad; // Picked channel has an illegal address
  logic go; // Start of a transfer
  logic drop; // Request dropped for bad address
  logic upd; // Unit finished
  logic wb_hit; // New bus access
  logic wb_wr; // New channel register write
  logic [1:0] wch; // Addressed channel
  logic [2:0] widx; // Addressed register
  logic fifo_in_rdy;
  logic fifo_out_vld;
  logic [31:0] fifo_data;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Byte-lane merge for Wishbone sel
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Limit a written count to the channel maximum
  function automatic logic [24:0] clamp(input logic [31:0] v);
    if (v > {7'h00, fcd_pkg::MAX_UNITS}) begin
      return fcd_pkg::MAX_UNITS;
    end
    return v[24:0];
  endfunction

  // Address step for a unit size
  function automatic logic [31:0] step(input logic [1:0] sz);
    case (sz)
      fcd_pkg::SZ_BYTE: return 32'h00000001;
      fcd_pkg::SZ_WORD: return 32'h00000002;
      default: return 32'h00000004;
    endcase
  endfunction

  // Address lies in one of the two legal windows
  function automatic logic addr_ok(input logic [31:0] a);
    return (a[31:25] == fcd_pkg::LOW_TOP7) || (a[31:25] == fcd_pkg::HIGH_TOP7);
  endfunction

  // Fixed priority pick
  function automatic logic [1:0] pick(input logic [3:0] p);
    if (p[0]) begin
      return 2'h0;
    end else if (p[1]) begin
      return 2'h1;
    end else if (p[2]) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode and control terms
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i && !wb_adr_i[7];
  assign wch = wb_adr_i[6:5];
  assign widx = wb_adr_i[4:2];
  assign pk = pick(pend);
  assign bad = !addr_ok(src[pk]) || !addr_ok(dst[pk]);
  assign go = (st == ST_IDLE) && (|pend) && !bad && fifo_in_rdy;
  assign drop = (st == ST_IDLE) && (|pend) && bad;
  assign upd = (st == ST_UPDATE);

  // Channel enable and request events
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      on[c] = ((mode[c].md == fcd_pkg::MD_SINGLE) || (mode[c].md == fcd_pkg::MD_REPEAT))
              && (count[c] != '0);
      trig[c] = wb_wr && (wch == 2'(c)) && (widx == fcd_pkg::IDX_SEL) && wb_sel_i[0]
                && wb_dat_i[fcd_pkg::SWREQ_BIT];
      case (rsel[c])
        fcd_pkg::SRC_SOFT: trig[c] = trig[c];
        fcd_pkg::SRC_FALL: trig[c] = trig[c] || (pin_d[c] && !pin_s2[c]);
        fcd_pkg::SRC_BOTH: trig[c] = trig[c] || (pin_d[c] != pin_s2[c]);
        default: begin
          if (int'(rsel[c] - fcd_pkg::SRC_PERIPH_BASE) < PERIPH_N) begin
            trig[c] = trig[c] || periph_irq[rsel[c] - fcd_pkg::SRC_PERIPH_BASE];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge memory
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      pin_d <= 4'hf;
    end else begin
      pin_s1 <= ext_irq_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // Pending requests; a new request wins over the clear
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (rst) begin
        pend[c] <= 1'b0;
      end else if (!on[c]) begin
        pend[c] <= 1'b0;
      end else if (trig[c]) begin
        pend[c] <= 1'b1;
      end else if ((upd || drop) && (((upd ? cur : pk)) == 2'(c))) begin
        pend[c] <= 1'b0;
      end
    end
  end

  // Address error flags, cleared by writing ones to status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (drop && (pk == 2'(c))) begin
          err[c] <= 1'b1;
        end else if (wb_hit && wb_we_i && (wb_adr_i == fcd_pkg::STATUS_ADDR) && wb_sel_i[0]
                     && wb_dat_i[4+c]) begin
          err[c] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= ST_IDLE;
      cur <= 2'h0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (go) begin
            st <= ST_READ;
            cur <= pk;
          end
        end
        ST_READ: if (mem_ack) st <= ST_POP;
        ST_POP: if (fifo_out_vld) st <= ST_WRITE;
        ST_WRITE: if (mem_ack) st <= ST_UPDATE;
        ST_UPDATE: st <= ST_IDLE;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Shared bus master request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_out <= '0;
    end else if (go) begin
      mem_out <= '{req: 1'b1, we: 1'b0, size: mode[pk].size, addr: src[pk],
                  wdata: fcd_pkg::RST_WORD};
    end else if ((st == ST_POP) && fifo_out_vld) begin
      mem_out <= '{req: 1'b1, we: 1'b1, size: mode[cur].size, addr: dst[cur],
                  wdata: fifo_data};
    end else if (((st == ST_READ) || (st == ST_WRITE)) && mem_ack) begin
      mem_out.req <= 1'b0;
    end
  end

  // CPU gets the bus only when no transfer wants it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_gnt <= 1'b0;
    end else begin
      cpu_gnt <= cpu_req && (st == ST_IDLE) && !(|pend) && !(|trig);
    end
  end

  // Completion request pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_irq <= 4'h0;
    end else if (upd && (count[cur] == 25'h0000001)) begin
      done_irq <= 4'h1 << cur;
    end else begin
      done_irq <= 4'h0;
    end
  end

  // Data FIFO between read and write halves
  fcd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid((st == ST_READ) && mem_ack),
    .in_ready(fifo_in_rdy),
    .in_data(mem_rdata),
    .out_valid(fifo_out_vld),
    .out_ready(st == ST_POP),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, software only
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (rst) begin
        mode[c] <= fcd_pkg::fcd_mode_type'(6'h00);
        crld[c] <= fcd_pkg::RST_WORD[24:0];
        srld[c] <= fcd_pkg::RST_WORD;
        drld[c] <= fcd_pkg::RST_WORD;
        rsel[c] <= fcd_pkg::SRC_SOFT;
      end else if (wb_wr && (wch == 2'(c))) begin
        case (widx)
          fcd_pkg::IDX_MODE: begin
            // Only the low six bits hold mode fields
            mode[c] <= fcd_pkg::fcd_mode_type'(6'(merge({26'h0, mode[c]}, wb_dat_i,
                                                        wb_sel_i)));
          end
          fcd_pkg::IDX_CRLD: crld[c] <= clamp(merge({7'h00, crld[c]}, wb_dat_i, wb_sel_i));
          fcd_pkg::IDX_SRLD: srld[c] <= merge(srld[c], wb_dat_i, wb_sel_i);
          fcd_pkg::IDX_DRLD: drld[c] <= merge(drld[c], wb_dat_i, wb_sel_i);
          fcd_pkg::IDX_SEL: if (wb_sel_i[0]) rsel[c] <= wb_dat_i[4:0];
          default: rsel[c] <= rsel[c];
        endcase
      end
    end
  end

  // Working counters and addresses; a software write wins over the engine
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (rst) begin
        count[c] <= fcd_pkg::RST_WORD[24:0];
        src[c] <= fcd_pkg::RST_WORD;
        dst[c] <= fcd_pkg::RST_WORD;
      end else if (wb_wr && (wch == 2'(c)) && (widx == fcd_pkg::IDX_COUNT)) begin
        count[c] <= clamp(merge({7'h00, count[c]}, wb_dat_i, wb_sel_i));
      end else if (wb_wr && (wch == 2'(c)) && (widx == fcd_pkg::IDX_SRC)) begin
        src[c] <= merge(src[c], wb_dat_i, wb_sel_i);
      end else if (wb_wr && (wch == 2'(c)) && (widx == fcd_pkg::IDX_DST)) begin
        dst[c] <= merge(dst[c], wb_dat_i, wb_sel_i);
      end else if (upd && (cur == 2'(c))) begin
        if ((count[c] == 25'h0000001) && (mode[c].md == fcd_pkg::MD_REPEAT)) begin
          count[c] <= crld[c];
          src[c] <= srld[c];
          dst[c] <= drld[c];
        end else begin
          count[c] <= count[c] - 1'b1;
          if (mode[c].src_inc) begin
            src[c] <= src[c] + step(mode[c].size);
          end
          if (mode[c].dst_inc) begin
            dst[c] <= dst[c] + step(mode[c].size);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    rdata = fcd_pkg::RST_WORD;
    if (wb_adr_i == fcd_pkg::STATUS_ADDR) begin
      rdata = {23'h0, (st != ST_IDLE), err, pend};
    end else if (!wb_adr_i[7]) begin
      case (widx)
        fcd_pkg::IDX_MODE: rdata = {26'h0, mode[wch]};
        fcd_pkg::IDX_COUNT: rdata = {7'h00, count[wch]};
        fcd_pkg::IDX_CRLD: rdata = {7'h00, crld[wch]};
        fcd_pkg::IDX_SRC: rdata = src[wch];
        fcd_pkg::IDX_SRLD: rdata = srld[wch];
        fcd_pkg::IDX_DST: rdata = dst[wch];
        fcd_pkg::IDX_DRLD: rdata = drld[wch];
        default: rdata = {22'h0, err[wch], pend[wch], 3'h0, rsel[wch]};
      endcase
    end
  end

  // Wishbone answer one cycle after the strobe, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= fcd_pkg::RST_WORD;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rdata : fcd_pkg::RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_prio;
    (go && pend[0]) |=> (cur == 2'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("lower channel served before channel 0");

  property p_cpu_block;
    (|pend) |=> !cpu_gnt;
  endproperty
  a_cpu_block: assert property (p_cpu_block) else $error("cpu granted while dma pending");

  property p_done;
    (upd && (count[cur] == 25'h0000001)) |=> (done_irq == (4'h1 << $past(cur)));
  endproperty
  a_done: assert property (p_done) else $error("completion pulse missing");

  property p_no_done;
    (upd && (count[cur] != 25'h0000001)) |=> (done_irq == 4'h0);
  endproperty
  a_no_done: assert property (p_no_done) else $error("spurious completion pulse");

  property p_reload;
    (upd && !wb_wr && (count[cur] == 25'h0000001) && (mode[cur].md == fcd_pkg::MD_REPEAT))
      |=> (count[$past(cur)] == $past(crld[cur])) && (dst[$past(cur)] == $past(drld[cur]));
  endproperty
  a_reload: assert property (p_reload) else $error("repeat reload wrong");

  property p_decr;
    (upd && !wb_wr && (count[cur] > 25'h0000001))
      |=> (count[$past(cur)] == $past(count[cur]) - 25'h0000001);
  endproperty
  a_decr: assert property (p_decr) else $error("counter did not decrement");

  property p_step;
    (upd && !wb_wr && (count[cur] > 25'h0000001) && mode[cur].src_inc)
      |=> (src[$past(cur)] == $past(src[cur]) + step($past(mode[cur].size)));
  endproperty
  a_step: assert property (p_step) else $error("source step wrong");

  property p_fixed;
    (upd && !wb_wr && (count[cur] > 25'h0000001) && !mode[cur].dst_inc)
      |=> (dst[$past(cur)] == $past(dst[cur]));
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed destination moved");

  property p_addr;
    mem_out.req |-> addr_ok(mem_out.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address outside legal windows");

  property p_off;
    (mode[0].md == fcd_pkg::MD_OFF) |=> !pend[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled channel still pending");

  property p_seq;
    go |=> mem_out.req && !mem_out.we && (st == ST_READ) && (mem_out.addr == $past(src[pk]));
  endproperty
  a_seq: assert property (p_seq) else $error("transfer did not open with a source read");

  c_single_done: cover property (upd && (mode[cur].md == fcd_pkg::MD_SINGLE)
                                 && (count[cur] == 25'h0000001));
  c_repeat_reload: cover property (upd && (mode[cur].md == fcd_pkg::MD_REPEAT)
                                   && (count[cur] == 25'h0000001));
  c_contention: cover property (go && (pend[0]) && (pend[3]));
  c_cpu_held: cover property (cpu_req && (|pend));
endmodule

// ### hdl/fcd_pkg.sv
// Package of constants and carrier types for the four-channel DMA controller
package fcd_pkg;
  // Channel count and counter width
  localparam int NUM_CH = 4;
  localparam int CNT_W = 25;
  // Largest unit count, the same for byte, word and long word units
  localparam logic [24:0] MAX_UNITS = 25'h1000000;
  // Register map: channel c at byte 0x20*c, word index in bits 4:2
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_COUNT = 3'h1;
  localparam logic [2:0] IDX_CRLD = 3'h2;
  localparam logic [2:0] IDX_SRC = 3'h3;
  localparam logic [2:0] IDX_SRLD = 3'h4;
  localparam logic [2:0] IDX_DST = 3'h5;
  localparam logic [2:0] IDX_DRLD = 3'h6;
  localparam logic [2:0] IDX_SEL = 3'h7;
  localparam logic [7:0] STATUS_ADDR = 8'h80;
  // Bits of the request select register
  localparam int SWREQ_BIT = 7;
  localparam int PEND_BIT = 8;
  localparam int ERR_BIT = 9;
  // Transfer mode field values
  localparam logic [1:0] MD_OFF = 2'h0;
  localparam logic [1:0] MD_SINGLE = 2'h1;
  localparam logic [1:0] MD_REPEAT = 2'h3;
  // Unit sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Request source select values; peripheral index is value minus base
  localparam logic [4:0] SRC_SOFT = 5'h00;
  localparam logic [4:0] SRC_FALL = 5'h01;
  localparam logic [4:0] SRC_BOTH = 5'h02;
  localparam logic [4:0] SRC_PERIPH_BASE = 5'h03;
  // Top seven address bits of the two legal address windows
  localparam logic [6:0] LOW_TOP7 = 7'h00;
  localparam logic [6:0] HIGH_TOP7 = 7'h7f;
  // Reset value of every register except the pin synchroniser and the edge memory, which reset to all ones
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // Channel mode register layout
  typedef struct packed {
    logic dst_inc;
    logic src_inc;
    logic [1:0] size;
    logic [1:0] md;
  } fcd_mode_type;
  // Request toward the shared memory bus
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fcd_mem_req_type;
endpackage
